// ---- logic/bst_pkg.sv ----
// Shared constants and types for the boundary-scan test port
package bst_pkg;

    // Test-port controller states
    typedef enum logic [3:0] {
        BST_TLR,
        BST_RTI,
        BST_SEL_DR,
        BST_CAP_DR,
        BST_SHIFT_DR,
        BST_EXIT1_DR,
        BST_PAUSE_DR,
        BST_EXIT2_DR,
        BST_UPD_DR,
        BST_SEL_IR,
        BST_CAP_IR,
        BST_SHIFT_IR,
        BST_EXIT1_IR,
        BST_PAUSE_IR,
        BST_EXIT2_IR,
        BST_UPD_IR
    } bst_tap_e;

    localparam int          BST_IR_LEN       = 3;
    localparam logic [2:0]  BST_OP_EXTEST    = 3'h0;
    localparam logic [2:0]  BST_OP_SAMPLE    = 3'h1;
    localparam logic [2:0]  BST_OP_USER1     = 3'h2;
    localparam logic [2:0]  BST_OP_USER2     = 3'h3;
    localparam logic [2:0]  BST_OP_READBACK  = 3'h4;
    localparam logic [2:0]  BST_OP_CONFIGURE = 3'h5;
    localparam logic [2:0]  BST_OP_RESERVED  = 3'h6;
    localparam logic [2:0]  BST_OP_BYPASS    = 3'h7;
    localparam logic [2:0]  BST_IR_CAPTURE   = 3'h1;

    // Boundary chain layout, position 0 nearest the serial output
    localparam int          BST_POS_SO_OE    = 0;
    localparam int          BST_POS_SO_IN    = 1;
    localparam int          BST_HEAD_BITS    = 2;
    localparam int          BST_TAIL_BITS    = 1;
    localparam int          BST_CELLS_IOB    = 3;
    localparam int          BST_CELL_IN      = 0;
    localparam int          BST_CELL_OUT     = 1;
    localparam int          BST_CELL_OE      = 2;

    localparam int          BST_SYNC_DEPTH   = 3;

endpackage

// ---- logic/bst_test_port.sv ----
// Boundary-scan test port: controller, instruction, boundary and bypass registers
//
// Contract
// R1: Supports bypass, sample/preload and external test
// R2: Scan option turns three pins into test inputs
// R3: No test reset pin; reset via states
// R4: Sixteen-state controller, instruction and data registers
// R5: Capture loads, shift moves data toward output
// R6: Update moves shifted bits into holding latches
// R7: Full pin has in, out, enable cells
// R8: Partial pins have input-only or output-only cell
// R9: External-test capture samples every input pin
// R10: Bypass is one retiming flip-flop
// R11: Two select outputs decode user instructions
// R12: User instruction drives output from fabric data
// R13: Data-register shift clock exported to fabric
// R14: Idle output is NAND of clock, idle
// R15: Eight instruction codes decode as listed
// R16: Configure disables pins; readback sends readback data
// R17: Per pin order: input, output, enable
// R18: Chain order top, left, bottom, right edges
// R19: Non-pin bits at 0, 1, and last
// R20: Configuration control pins have no cells
// R21: Without finished start-up, most instructions blocked
// R22: Standard state diagram, sample rise, drive fall
// R23: Output floats outside shift; bypass captures zero
`timescale 1ns/1ns

module bst_test_port
    import bst_pkg::*;
#(
    parameter int N_IOB      = 8,
    parameter int N_IN_ONLY  = 3,
    parameter int N_OUT_ONLY = 1
)(
    input  wire logic                  sys_clk,
    input  wire logic                  arst_n,
    input  wire logic                  cfg_scan_enable,
    input  wire logic                  cfg_startup_done,
    output logic                       test_pins_dedicated,
    output logic                       pins_under_test,
    input  wire logic                  tck,
    input  wire logic                  tms,
    input  wire logic                  tdi,
    output logic                       tdo,
    output logic                       tdo_oe,
    input  wire logic [N_IOB-1:0]      pad_in,
    input  wire logic [N_IOB-1:0]      core_out,
    input  wire logic [N_IOB-1:0]      core_oe,
    output logic      [N_IOB-1:0]      pad_out,
    output logic      [N_IOB-1:0]      pad_oe,
    input  wire logic [N_IN_ONLY-1:0]  in_only_pin,
    input  wire logic [N_OUT_ONLY-1:0] out_only_core,
    output logic      [N_OUT_ONLY-1:0] out_only_pin,
    input  wire logic                  user_scan_out_one,
    input  wire logic                  user_scan_out_two,
    input  wire logic                  readback_data,
    input  wire logic                  config_serial_out,
    output logic                       user_instr_one_select,
    output logic                       user_instr_two_select,
    output logic                       data_reg_shift_clock,
    output logic                       run_idle_gated_clock,
    output logic                       test_update_cell
);
    import bst_pkg::*;

    localparam int N_IN_ALL = N_IOB + N_IN_ONLY;
    localparam int IN_BASE  = BST_HEAD_BITS + BST_CELLS_IOB * N_IOB;
    localparam int OUT_BASE = IN_BASE + N_IN_ONLY;
    localparam int BSR_LEN  = OUT_BASE + N_OUT_ONLY + BST_TAIL_BITS;
    localparam int IOB0_IN  = BST_HEAD_BITS + BST_CELL_IN;

    if (N_IOB < 1 || N_IN_ONLY < 1 || N_OUT_ONLY < 1)
    begin : g_param_check
        $error("bst_test_port: every pin group needs at least one pin");
    end

    // System domain: configuration options, registered then sent to tck domain
    logic [1:0] cfg_q;
    logic [2:0] put_sync_q;
    logic       put_q;

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            cfg_q <= 2'h0;
        else
            cfg_q <= {cfg_startup_done, cfg_scan_enable};
    end

    assign test_pins_dedicated = cfg_q[0]; // R2

    // tck domain: configuration levels, three stages, change taken on agreement
    logic [1:0] cfg_s1_q;
    logic [1:0] cfg_s2_q;
    logic [1:0] cfg_s3_q;
    logic [1:0] cfg_t_q;
    logic       scan_en_t;
    logic       started_t;

    always_ff @(posedge tck or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cfg_s1_q <= 2'h0;
            cfg_s2_q <= 2'h0;
            cfg_s3_q <= 2'h0;
            cfg_t_q  <= 2'h0;
        end
        else
        begin
            cfg_s1_q <= cfg_q;
            cfg_s2_q <= cfg_s1_q;
            cfg_s3_q <= cfg_s2_q;
            for (int i = 0; i < 2; i++)
                if (cfg_s2_q[i] == cfg_s3_q[i])
                    cfg_t_q[i] <= cfg_s3_q[i];
        end
    end

    assign scan_en_t = cfg_t_q[0];
    assign started_t = cfg_t_q[1];

    // Pin inputs: three stages each; filtered value moves when 2nd and 3rd agree
    logic [N_IN_ALL-1:0] pin_all;
    logic [N_IN_ALL-1:0] pin_f;

    assign pin_all = {in_only_pin, pad_in};

    genvar g;
    generate
        for (g = 0; g < N_IN_ALL; g++)
        begin : g_pin_sync
            logic [BST_SYNC_DEPTH-1:0] s_q;
            logic                      f_q;
            always_ff @(posedge tck or negedge arst_n)
            begin
                if (!arst_n)
                begin
                    s_q <= '0;
                    f_q <= 1'b0;
                end
                else
                begin
                    s_q <= {s_q[BST_SYNC_DEPTH-2:0], pin_all[g]};
                    if (s_q[1] == s_q[2])
                        f_q <= s_q[2];
                end
            end
            assign pin_f[g] = f_q;
        end
    endgenerate

    // Controller; no test reset pin, only five TMS highs, a disabled option or arst_n
    bst_tap_e state_q;
    bst_tap_e state_d;

    always_comb
    begin
        state_d = state_q;
        case (state_q) // R22
            BST_TLR:      state_d = tms ? BST_TLR      : BST_RTI;
            BST_RTI:      state_d = tms ? BST_SEL_DR   : BST_RTI;
            BST_SEL_DR:   state_d = tms ? BST_SEL_IR   : BST_CAP_DR;
            BST_CAP_DR:   state_d = tms ? BST_EXIT1_DR : BST_SHIFT_DR;
            BST_SHIFT_DR: state_d = tms ? BST_EXIT1_DR : BST_SHIFT_DR;
            BST_EXIT1_DR: state_d = tms ? BST_UPD_DR   : BST_PAUSE_DR;
            BST_PAUSE_DR: state_d = tms ? BST_EXIT2_DR : BST_PAUSE_DR;
            BST_EXIT2_DR: state_d = tms ? BST_UPD_DR   : BST_SHIFT_DR;
            BST_UPD_DR:   state_d = tms ? BST_SEL_DR   : BST_RTI;
            BST_SEL_IR:   state_d = tms ? BST_TLR      : BST_CAP_IR;
            BST_CAP_IR:   state_d = tms ? BST_EXIT1_IR : BST_SHIFT_IR;
            BST_SHIFT_IR: state_d = tms ? BST_EXIT1_IR : BST_SHIFT_IR;
            BST_EXIT1_IR: state_d = tms ? BST_UPD_IR   : BST_PAUSE_IR;
            BST_PAUSE_IR: state_d = tms ? BST_EXIT2_IR : BST_PAUSE_IR;
            BST_EXIT2_IR: state_d = tms ? BST_UPD_IR   : BST_SHIFT_IR;
            BST_UPD_IR:   state_d = tms ? BST_SEL_DR   : BST_RTI;
            default:      state_d = BST_TLR;
        endcase
    end

    always_ff @(posedge tck or negedge arst_n)
    begin
        if (!arst_n)
            state_q <= BST_TLR;
        else if (!scan_en_t)
            state_q <= BST_TLR; // R2 R3
        else
            state_q <= state_d; // R4 R22
    end

    // Instruction register: shift stage on rise, holding latch on fall
    logic [BST_IR_LEN-1:0] ir_sr_q;
    logic [BST_IR_LEN-1:0] instr_q;
    logic [BST_IR_LEN-1:0] ir_gated;

    // Before start-up finishes only configure survives; the rest fall to bypass
    always_comb
    begin
        if (!started_t && ir_sr_q != BST_OP_CONFIGURE)
            ir_gated = BST_OP_BYPASS; // R21
        else
            ir_gated = ir_sr_q;
    end

    always_ff @(posedge tck or negedge arst_n)
    begin
        if (!arst_n)
            ir_sr_q <= BST_OP_BYPASS;
        else if (state_q == BST_CAP_IR)
            ir_sr_q <= BST_IR_CAPTURE; // R5
        else if (state_q == BST_SHIFT_IR)
            ir_sr_q <= {tdi, ir_sr_q[BST_IR_LEN-1:1]}; // R5
    end

    always_ff @(negedge tck or negedge arst_n)
    begin
        if (!arst_n)
            instr_q <= BST_OP_BYPASS;
        else if (state_q == BST_TLR)
            instr_q <= BST_OP_BYPASS;
        else if (state_q == BST_UPD_IR)
            instr_q <= ir_gated; // R6
    end

    logic op_extest;
    logic op_bsr;

    assign op_extest = (instr_q == BST_OP_EXTEST); // R15
    assign op_bsr    = op_extest || (instr_q == BST_OP_SAMPLE); // R1
    assign user_instr_one_select = (instr_q == BST_OP_USER1); // R11
    assign user_instr_two_select = (instr_q == BST_OP_USER2); // R11

    // Boundary register capture vector, chain order fixed by pin index
    logic [BSR_LEN-1:0] bsr_cap;
    logic [BSR_LEN-1:0] bsr_q;
    logic [BSR_LEN-1:0] upd_q;
    logic               tdo_q;
    logic               tdo_oe_q;

    assign bsr_cap[BST_POS_SO_OE] = tdo_oe_q; // R19
    assign bsr_cap[BST_POS_SO_IN] = tdo_q; // R19
    assign bsr_cap[BSR_LEN-1]     = 1'b0; // R19

    // Pin k is the k-th block walking top, left, bottom, right edges
    generate
        for (g = 0; g < N_IOB; g++)
        begin : g_iob_cells
            localparam int B = BST_HEAD_BITS + BST_CELLS_IOB * g;
            assign bsr_cap[B+BST_CELL_IN]  = pin_f[g]; // R7 R9 R17 R18
            assign bsr_cap[B+BST_CELL_OUT] = core_out[g]; // R7 R17
            assign bsr_cap[B+BST_CELL_OE]  = core_oe[g]; // R7 R17
            assign pad_out[g] = op_extest ? upd_q[B+BST_CELL_OUT] : core_out[g];
            assign pad_oe[g]  = (instr_q == BST_OP_CONFIGURE) ? 1'b0 // R16
                              : op_extest ? upd_q[B+BST_CELL_OE] : core_oe[g];
        end
        for (g = 0; g < N_IN_ONLY; g++)
        begin : g_in_cells
            assign bsr_cap[IN_BASE+g] = pin_f[N_IOB+g]; // R8 R9
        end
        for (g = 0; g < N_OUT_ONLY; g++)
        begin : g_out_cells
            assign bsr_cap[OUT_BASE+g] = out_only_core[g]; // R8
            assign out_only_pin[g] = op_extest ? upd_q[OUT_BASE+g] : out_only_core[g];
        end
    endgenerate

    // Configuration control pins are simply absent from the chain
    always_ff @(posedge tck or negedge arst_n)
    begin
        if (!arst_n)
            bsr_q <= '0;
        else if (op_bsr && state_q == BST_CAP_DR)
            bsr_q <= bsr_cap; // R5 R9 R20
        else if (op_bsr && state_q == BST_SHIFT_DR)
            bsr_q <= {tdi, bsr_q[BSR_LEN-1:1]}; // R5
    end

    // Update latches change on the fall so pins never move mid-shift
    always_ff @(negedge tck or negedge arst_n)
    begin
        if (!arst_n)
            upd_q <= '0;
        else if (op_bsr && state_q == BST_UPD_DR)
            upd_q <= bsr_q; // R6
    end

    assign test_update_cell = upd_q[BSR_LEN-1]; // R19

    // Bypass stage; shifts in every data-register scan, whatever the instruction
    logic bypass_q;

    always_ff @(posedge tck or negedge arst_n)
    begin
        if (!arst_n)
            bypass_q <= 1'b0;
        else if (state_q == BST_CAP_DR)
            bypass_q <= 1'b0; // R23
        else if (state_q == BST_SHIFT_DR)
            bypass_q <= tdi; // R10
    end

    // Serial output source and its fall-edge stage
    logic tdo_d;
    logic in_shift;

    assign in_shift = (state_q == BST_SHIFT_DR) || (state_q == BST_SHIFT_IR);

    always_comb
    begin
        tdo_d = bypass_q;
        if (state_q == BST_SHIFT_IR)
            tdo_d = ir_sr_q[0];
        else
        begin
            case (instr_q) // R15
                BST_OP_EXTEST,
                BST_OP_SAMPLE:    tdo_d = bsr_q[0];
                BST_OP_USER1:     tdo_d = user_scan_out_one; // R12
                BST_OP_USER2:     tdo_d = user_scan_out_two; // R12
                BST_OP_READBACK:  tdo_d = readback_data; // R16
                BST_OP_CONFIGURE: tdo_d = config_serial_out; // R16
                default:          tdo_d = bypass_q; // R10
            endcase
        end
    end

    logic drck_en_q;
    logic idle_q;

    always_ff @(negedge tck or negedge arst_n)
    begin
        if (!arst_n)
        begin
            tdo_q     <= 1'b0;
            tdo_oe_q  <= 1'b0;
        end
        else
        begin
            tdo_q    <= tdo_d; // R22
            tdo_oe_q <= in_shift; // R23
        end
    end

    // Gate enables held on the fall so the gated clocks carry no runt pulses
    always_ff @(negedge tck or negedge arst_n)
    begin
        if (!arst_n)
        begin
            drck_en_q <= 1'b0;
            idle_q    <= 1'b0;
        end
        else
        begin
            drck_en_q <= (state_q == BST_CAP_DR) || (state_q == BST_SHIFT_DR);
            idle_q    <= (state_q == BST_RTI);
        end
    end

    assign tdo                  = tdo_q;
    assign tdo_oe               = tdo_oe_q;
    assign data_reg_shift_clock = tck & drck_en_q; // R13
    assign run_idle_gated_clock = ~(tck & idle_q); // R14

    // External test state handed back to the system clock
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            put_sync_q <= 3'h0;
            put_q      <= 1'b0;
        end
        else
        begin
            put_sync_q <= {put_sync_q[1:0], op_extest};
            if (put_sync_q[1] == put_sync_q[2])
                put_q <= put_sync_q[2];
        end
    end

    assign pins_under_test = put_q;

    // Checks
    property p_tms_reset;
        @(posedge tck) disable iff (!arst_n)
        tms [*5] |=> state_q == BST_TLR;
    endproperty
    a_tms_reset: assert property (p_tms_reset) else $error("no reset after 5 tms"); // R3

    property p_disabled_idle;
        @(posedge tck) disable iff (!arst_n)
        !scan_en_t |=> state_q == BST_TLR && tdo_oe == 1'b0;
    endproperty
    a_disabled_idle: assert property (p_disabled_idle) else $error("port active while off"); // R2

    property p_ir_capture;
        @(posedge tck) disable iff (!arst_n)
        state_q == BST_CAP_IR |=> ir_sr_q == BST_IR_CAPTURE;
    endproperty
    a_ir_capture: assert property (p_ir_capture) else $error("bad ir capture"); // R5

    property p_ir_update;
        @(posedge tck) disable iff (!arst_n)
        state_q == BST_UPD_IR |=> instr_q == $past(ir_gated);
    endproperty
    a_ir_update: assert property (p_ir_update) else $error("ir not updated"); // R6

    property p_bypass_path;
        @(posedge tck) disable iff (!arst_n)
        state_q == BST_CAP_DR ##1 state_q == BST_SHIFT_DR |=> bypass_q == $past(tdi)
            && $past(bypass_q) == 1'b0;
    endproperty
    a_bypass_path: assert property (p_bypass_path) else $error("bypass path wrong"); // R10

    property p_extest_capture;
        @(posedge tck) disable iff (!arst_n)
        op_extest && state_q == BST_CAP_DR |=> bsr_q[IOB0_IN] == $past(pin_f[0]);
    endproperty
    a_extest_capture: assert property (p_extest_capture) else $error("pin not sampled"); // R9

    property p_user_select;
        @(negedge tck) disable iff (!arst_n)
        user_instr_one_select && state_q == BST_SHIFT_DR |=> tdo == $past(user_scan_out_one);
    endproperty
    a_user_select: assert property (p_user_select) else $error("user data not on tdo"); // R12

    property p_configure_off;
        @(posedge tck) disable iff (!arst_n)
        instr_q == BST_OP_CONFIGURE |-> pad_oe == '0;
    endproperty
    a_configure_off: assert property (p_configure_off) else $error("pins on in configure"); // R16

    property p_not_started;
        @(posedge tck) disable iff (!arst_n)
        !started_t && state_q == BST_UPD_IR |=> instr_q != BST_OP_READBACK;
    endproperty
    a_not_started: assert property (p_not_started) else $error("readback before start"); // R21

    property p_tdo_float;
        @(negedge tck) disable iff (!arst_n)
        !in_shift |=> !tdo_oe;
    endproperty
    a_tdo_float: assert property (p_tdo_float) else $error("tdo driven outside shift"); // R23

    c_extest: cover property (@(posedge tck) disable iff (!arst_n)
        op_extest && state_q == BST_UPD_DR);
    c_user_shift: cover property (@(posedge tck) disable iff (!arst_n)
        user_instr_two_select && state_q == BST_SHIFT_DR);
    c_pause_dr: cover property (@(posedge tck) disable iff (!arst_n)
        state_q == BST_PAUSE_DR ##1 state_q == BST_EXIT2_DR ##1 state_q == BST_SHIFT_DR);
    c_configure: cover property (@(posedge tck) disable iff (!arst_n)
        instr_q == BST_OP_CONFIGURE && state_q == BST_SHIFT_DR);

endmodule

// ---- sim/bst_jtag_ctl.sv ----
// Board-side test controller model that drives the serial test port
`timescale 1ns/1ns

module bst_jtag_ctl (
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    input  wire logic tdo
);
    localparam int HALF = 80;

    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end

    // Clock stands low between frames; tms and tdi move only while it is low
    task automatic step(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #HALF;
        tck = 1'b1;
        q = tdo;
        #HALF;
        tck = 1'b0;
    endtask

    task automatic idle(input int n, input logic m);
        logic q;
        repeat (n) step(m, 1'b0, q);
    endtask

    // From run-test/idle: select, capture, shift, exit, update, back to idle
    task automatic scan(input logic ir, input int n, input logic [31:0] vin,
                        output logic [31:0] vout);
        logic q;
        vout = '0;
        step(1'b1, 1'b0, q);
        if (ir)
            step(1'b1, 1'b0, q);
        step(1'b0, 1'b0, q);
        step(1'b0, 1'b0, q);
        for (int i = 0; i < n; i++)
        begin
            step(i == n - 1, vin[i], q);
            vout[i] = q;
        end
        step(1'b1, 1'b0, q);
        step(1'b0, 1'b0, q);
    endtask
endmodule

// ---- sim/bst_test_port_tb_top.sv ----
// Self-checking bench for the boundary-scan test port
`timescale 1ns/1ns

module bst_test_port_tb_top;
    import bst_pkg::*;

    localparam int NI = 4;
    localparam int NN = 2;
    localparam int NO = 1;
    localparam int BL = 2 + 3 * NI + NN + NO + 1;

    logic          sys_clk = 1'b0;
    logic          arst_n;
    logic          cfg_scan_enable;
    logic          cfg_startup_done;
    logic          test_pins_dedicated;
    logic          pins_under_test;
    logic          tck;
    logic          tms;
    logic          tdi;
    logic          tdo;
    logic          tdo_oe;
    logic [NI-1:0] pad_in;
    logic [NI-1:0] core_out;
    logic [NI-1:0] core_oe;
    logic [NI-1:0] pad_out;
    logic [NI-1:0] pad_oe;
    logic [NN-1:0] in_only_pin;
    logic [NO-1:0] out_only_core;
    logic [NO-1:0] out_only_pin;
    logic          usr_one;
    logic          usr_two;
    logic          readback_data;
    logic          config_serial_out;
    logic          sel_one;
    logic          sel_two;
    logic          dr_clk;
    logic          idle_clk;
    logic          test_update_cell;
    logic [31:0]   seed = 32'hd9ed;
    int            mismatches = 0;
    int            num_checks = 0;
    int            drck_pulses = 0;
    int            idle_pulses = 0;

    always #4 sys_clk = ~sys_clk;

    always @(posedge dr_clk)
        drck_pulses++;

    always @(negedge idle_clk)
        idle_pulses++;

    bst_test_port #(.N_IOB(NI), .N_IN_ONLY(NN), .N_OUT_ONLY(NO)) u_bst_test_port (
        .sys_clk(sys_clk), .arst_n(arst_n), .cfg_scan_enable(cfg_scan_enable),
        .cfg_startup_done(cfg_startup_done), .test_pins_dedicated(test_pins_dedicated),
        .pins_under_test(pins_under_test), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
        .tdo_oe(tdo_oe), .pad_in(pad_in), .core_out(core_out), .core_oe(core_oe),
        .pad_out(pad_out), .pad_oe(pad_oe), .in_only_pin(in_only_pin),
        .out_only_core(out_only_core), .out_only_pin(out_only_pin),
        .user_scan_out_one(usr_one), .user_scan_out_two(usr_two),
        .readback_data(readback_data), .config_serial_out(config_serial_out),
        .user_instr_one_select(sel_one), .user_instr_two_select(sel_two),
        .data_reg_shift_clock(dr_clk), .run_idle_gated_clock(idle_clk),
        .test_update_cell(test_update_cell));

    bst_jtag_ctl u_bst_jtag_ctl (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Expected boundary capture; bit 1 is the serial output itself and is masked
    function automatic logic [31:0] cap_exp();
        logic [31:0] e;
        e = '0;
        for (int k = 0; k < NI; k++)
        begin
            e[2+3*k] = pad_in[k];
            e[3+3*k] = core_out[k];
            e[4+3*k] = core_oe[k];
        end
        e[2+3*NI +: NN] = in_only_pin;
        e[2+3*NI+NN] = out_only_core[0];
        return e;
    endfunction

    function automatic logic [NI-1:0] every3(input logic [31:0] v, input int b);
        for (int k = 0; k < NI; k++)
            every3[k] = v[b+3*k];
    endfunction

    function automatic logic [7:0] dr_exp(input logic [2:0] c, input logic [7:0] v);
        case (c)
            3'h2: return {8{usr_one}};
            3'h3: return {8{usr_two}};
            3'h4: return {8{readback_data}};
            3'h5: return {8{config_serial_out}};
            default: return {v[6:0], 1'b0};
        endcase
    endfunction

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Offset keeps test-clock edges clear of system-clock edges
    task automatic drive_pins();
        @(posedge sys_clk);
        seed = lfsr(seed);
        pad_in <= seed[3:0];
        core_out <= seed[7:4];
        core_oe <= seed[11:8];
        in_only_pin <= seed[13:12];
        out_only_core <= seed[14];
        usr_one <= seed[15];
        usr_two <= seed[16];
        readback_data <= seed[17];
        config_serial_out <= seed[18];
        #3;
    endtask

    task automatic pin_check(input logic [31:0] p);
        check("pad_out", every3(p, 3), pad_out);
        check("pad_oe", every3(p, 4), pad_oe);
        check("out_only_pin", p[2+3*NI+NN], out_only_pin);
        check("test_update_cell", p[BL-1], test_update_cell);
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial
    begin
        logic [31:0] o;
        logic [31:0] p;
        logic [2:0]  code;
        int          d0;
        arst_n = 1'b0;
        cfg_scan_enable = 1'b1;
        cfg_startup_done = 1'b0;
        {pad_in, core_out, core_oe, in_only_pin, out_only_core} = '0;
        {usr_one, usr_two, readback_data, config_serial_out} = '0;
        repeat (4) @(posedge sys_clk);
        arst_n <= 1'b1;
        #3;
        check("tdo_oe", 0, tdo_oe);
        check("idle clock", 1, idle_clk);
        u_bst_jtag_ctl.idle(8, 1'b1);
        check("pins dedicated", 1, test_pins_dedicated);
        u_bst_jtag_ctl.idle(1, 1'b0);
        u_bst_jtag_ctl.scan(1'b1, 3, BST_OP_USER1, o);
        check("ir capture", BST_IR_CAPTURE, o);
        check("select one blocked", 0, sel_one);
        @(posedge sys_clk);
        cfg_startup_done <= 1'b1;
        d0 = idle_pulses;
        u_bst_jtag_ctl.idle(6, 1'b0);
        check("idle clock pulses", 6, idle_pulses - d0);
        for (int c = 0; c < 16; c++)
        begin
            code = c[2:0];
            drive_pins();
            u_bst_jtag_ctl.scan(1'b1, 3, code, o);
            check("select one", code == BST_OP_USER1, sel_one);
            check("select two", code == BST_OP_USER2, sel_two);
            if (code == BST_OP_CONFIGURE)
                check("pad_oe off", 0, pad_oe);
            if (code != BST_OP_CONFIGURE && code != BST_OP_EXTEST)
                check("pad_out logic", core_out, pad_out);
            seed = lfsr(seed);
            if (code > BST_OP_SAMPLE)
            begin
                d0 = drck_pulses;
                u_bst_jtag_ctl.scan(1'b0, 8, seed, o);
                check("dr out", dr_exp(code, seed[7:0]), o);
                check("dr clock pulses", 9, drck_pulses - d0);
            end
        end
        drive_pins();
        u_bst_jtag_ctl.scan(1'b1, 3, BST_OP_SAMPLE, o);
        u_bst_jtag_ctl.idle(5, 1'b0);
        seed = lfsr(seed);
        p = seed & ((32'h1 << BL) - 1);
        u_bst_jtag_ctl.scan(1'b0, BL, p, o);
        check("sample capture", cap_exp(), o & ~32'h2);
        u_bst_jtag_ctl.scan(1'b1, 3, BST_OP_EXTEST, o);
        pin_check(p);
        for (int i = 0; i < 20 && pins_under_test !== 1'b1; i++)
            @(posedge sys_clk);
        check("pins under test", 1, pins_under_test);
        drive_pins();
        u_bst_jtag_ctl.idle(5, 1'b0);
        seed = lfsr(seed);
        p = seed & ((32'h1 << BL) - 1);
        u_bst_jtag_ctl.scan(1'b0, BL, p, o);
        check("extest capture", cap_exp(), o & ~32'h2);
        pin_check(p);
        u_bst_jtag_ctl.scan(1'b1, 3, BST_OP_USER2, o);
        check("select two on", 1, sel_two);
        u_bst_jtag_ctl.idle(5, 1'b1);
        check("select two after reset", 0, sel_two);
        u_bst_jtag_ctl.idle(1, 1'b0);
        @(posedge sys_clk);
        cfg_scan_enable <= 1'b0;
        u_bst_jtag_ctl.idle(6, 1'b0);
        check("pins dedicated off", 0, test_pins_dedicated);
        u_bst_jtag_ctl.scan(1'b1, 3, BST_OP_USER1, o);
        check("select one while off", 0, sel_one);
        check("tdo_oe while off", 0, tdo_oe);
        results();
    end
endmodule
